// ### hdl/cplc_top.v
// top of the cable port and link power control block
//
// How it works
// - received bits grouped 2/4/8 by packet speed, retimed to system clock
// - received packet repeated on every other active connected port
// - arbitration status taken from pair a and pair b comparators
// - pair a common mode during arbitration selects next packet speed
// - pair b common mode reports remote bias per port
// - power class pins and contender pin give four self-id defaults
// - suspended port moves no packets but keeps both detectors working
// - all three ports suspended drops core power; clock generator and bias detection stay on
// - own bias off: pair a common mode is the connect-detect
// - port tx/rx off on power-down, reset, no cable, or arbitration
// - port bias off on power-down, reset, or link disable command
// - no-cable flag high when all ports disconnected, unfiltered, works powered down
// - link power status low over 25 us deactivates link interface
// - repeating continues while link interface is deactivated
// - link-on packet starts square wave on contender/link-on pin
// - on status high, stop square wave first, then enable interface
// - transmit groups of 2/4/8 bits latched per clock, then serialised
// - power-down stops clock generator, leaves pair b bias detectors
`timescale 1ns/1ps
`default_nettype none
`include "cplc_consts.vh"

module cplc_top (
    input wire sys_clk_in,
    input wire rst_in,
    // ahb-lite slave
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output reg [31:0] hrdata_out,
    output wire hreadyout_out,
    output wire hresp_out,
    // analog comparator levels, per port
    input wire [5:0] cable_pair_a_line_in,
    input wire [5:0] cable_pair_b_line_in,
    input wire [5:0] cable_pair_a_speed_in,
    input wire [2:0] cable_pair_b_bias_in,
    input wire [2:0] cable_pair_a_connect_in,
    // decoded receive stream
    input wire rx_bit_clk_in,
    input wire rx_bit_in,
    input wire rx_active_in,
    input wire [2:0] rx_port_in,
    input wire [1:0] rx_speed_in,
    input wire linkon_pkt_in,
    // internal arbitration control
    input wire arb_phase_in,
    input wire [2:0] arb_disable_in,
    // straps and power
    input wire [2:0] power_class_inputs_in,
    input wire power_down_input_in,
    input wire link_power_status_in,
    input wire contender_linkon_pin_in,
    output reg contender_linkon_pin_out,
    output wire contender_linkon_pin_oe_out,
    // link controller data
    output reg [7:0] link_rx_data_out,
    output reg link_rx_valid_out,
    input wire [7:0] link_tx_data_in,
    input wire [1:0] link_tx_speed_in,
    input wire link_tx_valid_in,
    output wire link_tx_ready_out,
    output reg tx_bit_out,
    output wire [2:0] tx_port_en_out,
    // repeater and port outputs
    output reg rep_bit_out,
    output reg [2:0] rep_port_en_out,
    output wire [2:0] port_bias_output_en_out,
    output wire [2:0] port_trx_en_out,
    output wire [2:0] bias_detect_out,
    output reg [11:0] arb_status_out,
    output reg [1:0] next_speed_out,
    output reg [3:0] self_id_cfg_out,
    output wire no_cable_active_flag_out,
    output wire link_if_active_out,
    output wire clock_gen_en_out,
    output wire core_power_en_out
);

    // ****
    // input synchronisers
    // ****
    localparam SW = 38;
    wire [SW-1:0] sync_vec;
    wire [5:0] pa_line;
    wire [5:0] pb_line;
    wire [5:0] pa_speed;
    wire [2:0] pb_bias;
    wire [2:0] pa_conn;
    wire [2:0] rx_port;
    wire [2:0] pclass;
    wire rx_clk_s;
    wire rx_bit_s;
    wire rx_act_s;
    wire pd_s;
    wire lps_s;
    wire cont_s;
    wire [1:0] rx_spd_s;

    // pins and link clock pass two flops first
    cplc_sync #(.W(SW)) u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in({rx_speed_in, cable_pair_a_line_in, cable_pair_b_line_in,
                   cable_pair_a_speed_in, cable_pair_b_bias_in, cable_pair_a_connect_in,
                   rx_port_in, power_class_inputs_in, rx_bit_clk_in, rx_bit_in,
                   rx_active_in, power_down_input_in, link_power_status_in,
                   contender_linkon_pin_in}),
        .sync_out(sync_vec)
    );
    assign {rx_spd_s, pa_line, pb_line, pa_speed, pb_bias, pa_conn, rx_port, pclass,
            rx_clk_s, rx_bit_s, rx_act_s, pd_s, lps_s, cont_s} = sync_vec;

    // ****
    // software control register
    // ****
    reg [2:0] port_dis;
    reg [2:0] port_susp;
    reg wr_pend;
    reg [31:0] wr_addr;

    // ****
    // per-port enables and detection
    // ****
    wire [2:0] connected;
    wire all_susp;

    // all ports suspended: core power goes, bias detectors stay
    assign all_susp = &port_susp;
    assign core_power_en_out = ~pd_s & ~all_susp;
    assign clock_gen_en_out = ~pd_s;
    // pair b bias detectors run regardless of power-down
    assign bias_detect_out = pb_bias;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_port
            cplc_port u_port (
                .power_down_in(pd_s),
                .rst_in(rst_in),
                .link_disable_in(port_dis[gi]),
                .suspend_in(port_susp[gi]),
                .core_off_in(all_susp),
                .arb_disable_in(arb_disable_in[gi]),
                .bias_detect_in(pb_bias[gi]),
                .connect_detect_in(pa_conn[gi]),
                .bias_en_out(port_bias_output_en_out[gi]),
                .connected_out(connected[gi]),
                .port_en_out(port_trx_en_out[gi])
            );
        end
    endgenerate

    // and of disconnected ports, unfiltered so it tracks the cable
    assign no_cable_active_flag_out = &(~connected);

    // ****
    // arbitration status and speed signalling
    // ****
    reg [1:0] spd_max;
    integer si;

    // fastest speed signalled on any enabled port wins
    always @*
    begin
        spd_max = `CPLC_SPD_S100;
        for (si = 0; si < 3; si = si + 1)
        begin
            if (port_trx_en_out[si] && pa_speed[2*si +: 2] > spd_max)
            begin
                spd_max = pa_speed[2*si +: 2];
            end
        end
    end

    // line states held between arbitration phases
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            arb_status_out <= 12'h000;
            next_speed_out <= `CPLC_SPD_S100;
        end
        else if (arb_phase_in)
        begin
            arb_status_out <= {pa_line[5:4], pb_line[5:4], pa_line[3:2], pb_line[3:2],
                               pa_line[1:0], pb_line[1:0]};
            next_speed_out <= spd_max;
        end
    end

    // ****
    // self-id defaults caught after reset release
    // ****
    reg [1:0] cfg_cnt;

    // straps taken once the cleared synchroniser has refilled
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            cfg_cnt <= 2'h0;
            self_id_cfg_out <= 4'h0;
        end
        else if (cfg_cnt != 2'h3)
        begin
            cfg_cnt <= cfg_cnt + 2'h1;
            if (cfg_cnt == 2'h2)
            begin
                self_id_cfg_out <= {cont_s, pclass};
            end
        end
    end

    // ****
    // link power state machine
    // ****
    localparam ST_OFF = 4'b0001;
    localparam ST_WAVE = 4'b0010;
    localparam ST_STOP = 4'b0100;
    localparam ST_ON = 4'b1000;
    localparam [11:0] LPS_CYC = `CPLC_LPS_LOW_CYC;
    localparam [4:0] HALF_CYC = `CPLC_LKON_HALF_CYC;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [11:0] lps_cnt;
    reg [4:0] div_cnt;
    wire lps_expired;

    // low time counted in system clocks; any high sample restarts it
    always @(posedge sys_clk_in)
    begin
        if (rst_in || lps_s)
        begin
            lps_cnt <= 12'h000;
        end
        else if (!lps_expired)
        begin
            lps_cnt <= lps_cnt + 12'h001;
        end
    end
    assign lps_expired = (lps_cnt == LPS_CYC);

    always @*
    begin
        next_state = state;
        case (state)
            ST_OFF:
            begin
                if (linkon_pkt_in)
                begin
                    next_state = ST_WAVE;
                end
                else if (lps_s)
                begin
                    next_state = ST_ON;
                end
            end
            ST_WAVE:
            begin
                if (lps_s)
                begin
                    next_state = ST_STOP;
                end
            end
            ST_STOP:
            begin
                next_state = ST_ON;
            end
            ST_ON:
            begin
                if (lps_expired)
                begin
                    next_state = ST_OFF;
                end
            end
            default:
            begin
                next_state = ST_OFF;
            end
        endcase
    end

    // square wave divided from the system clock while waiting for the link
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            state <= ST_OFF;
            div_cnt <= 5'h00;
            contender_linkon_pin_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (next_state != ST_WAVE)
            begin
                div_cnt <= 5'h00;
                contender_linkon_pin_out <= 1'b0;
            end
            else if (div_cnt == HALF_CYC - 5'h01)
            begin
                div_cnt <= 5'h00;
                contender_linkon_pin_out <= ~contender_linkon_pin_out;
            end
            else
            begin
                div_cnt <= div_cnt + 5'h01;
            end
        end
    end
    // drive the pin only while signalling; straps read it otherwise
    assign contender_linkon_pin_oe_out = (state == ST_WAVE);
    assign link_if_active_out = (state == ST_ON) & ~pd_s;

    // ****
    // receive: repeat and deserialise
    // ****
    reg rx_clk_d;
    reg [7:0] rx_shift;
    reg [2:0] rx_cnt;
    wire rx_edge;
    wire [2:0] rx_last;

    assign rx_edge = rx_clk_s & ~rx_clk_d;
    assign rx_last = (rx_spd_s == `CPLC_SPD_S400) ? 3'd7 :
                     (rx_spd_s == `CPLC_SPD_S200) ? 3'd3 : 3'd1;

    // repeating ignores the link interface state so the bus keeps working
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            rx_clk_d <= 1'b0;
            rx_shift <= 8'h00;
            rx_cnt <= 3'd0;
            rep_bit_out <= 1'b0;
            rep_port_en_out <= 3'h0;
            link_rx_data_out <= 8'h00;
            link_rx_valid_out <= 1'b0;
        end
        else
        begin
            rx_clk_d <= rx_clk_s;
            link_rx_valid_out <= 1'b0;
            rep_port_en_out <= rx_act_s ? (port_trx_en_out & ~rx_port) : 3'h0;
            if (!rx_act_s)
            begin
                rx_cnt <= 3'd0;
            end
            else if (rx_edge)
            begin
                rep_bit_out <= rx_bit_s;
                rx_shift <= {rx_shift[6:0], rx_bit_s};
                if (rx_cnt == rx_last)
                begin
                    rx_cnt <= 3'd0;
                    // a group reaches the link only while its interface is awake
                    if (link_if_active_out)
                    begin
                        link_rx_data_out <= {rx_shift[6:0], rx_bit_s};
                        link_rx_valid_out <= 1'b1;
                    end
                end
                else
                begin
                    rx_cnt <= rx_cnt + 3'd1;
                end
            end
        end
    end

    // ****
    // transmit: latch a group, shift it out msb first
    // ****
    reg [7:0] tx_shift;
    reg [3:0] tx_left;

    // no new group is taken until the previous one has left
    assign link_tx_ready_out = (tx_left == 4'd0) & link_if_active_out & ~rx_act_s;
    assign tx_port_en_out = (tx_left != 4'd0) ? port_trx_en_out : 3'h0;

    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            tx_shift <= 8'h00;
            tx_left <= 4'd0;
            tx_bit_out <= 1'b0;
        end
        else if (link_tx_valid_in && link_tx_ready_out)
        begin
            tx_left <= (link_tx_speed_in == `CPLC_SPD_S400) ? 4'd8 :
                       (link_tx_speed_in == `CPLC_SPD_S200) ? 4'd4 : 4'd2;
            tx_shift <= (link_tx_speed_in == `CPLC_SPD_S400) ? link_tx_data_in :
                        (link_tx_speed_in == `CPLC_SPD_S200) ? {link_tx_data_in[3:0], 4'h0} :
                        {link_tx_data_in[1:0], 6'h00};
        end
        else if (tx_left != 4'd0)
        begin
            tx_bit_out <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
            tx_left <= tx_left - 4'd1;
        end
    end

    // ****
    // ahb-lite slave, zero wait states
    // ****
    wire [31:0] st_word;
    wire addr_ok;

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign addr_ok = hsel_in & hready_in & (htrans_in == `CPLC_HTRANS_NONSEQ);
    assign st_word = {18'h0_0000, next_speed_out, core_power_en_out,
                      contender_linkon_pin_oe_out, link_if_active_out,
                      no_cable_active_flag_out, 1'b0, pb_bias, 1'b0, connected};

    // read data registered in the address phase so it stands in the data phase
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
            hrdata_out <= 32'h0000_0000;
            port_dis <= 3'h0;
            port_susp <= 3'h0;
        end
        else
        begin
            wr_pend <= addr_ok & hwrite_in;
            wr_addr <= haddr_in;
            if (addr_ok && !hwrite_in)
            begin
                case (haddr_in)
                    `CPLC_REG_CTRL: hrdata_out <= {25'h000_0000, port_susp, 1'b0, port_dis};
                    `CPLC_REG_STATUS: hrdata_out <= st_word;
                    `CPLC_REG_CONFIG: hrdata_out <= {28'h000_0000, self_id_cfg_out};
                    `CPLC_REG_ARB: hrdata_out <= {20'h0_0000, arb_status_out};
                    default: hrdata_out <= 32'h0000_0000;
                endcase
            end
            if (wr_pend && wr_addr == `CPLC_REG_CTRL)
            begin
                port_dis <= hwdata_in[`CPLC_CTRL_DIS_LSB +: 3];
                port_susp <= hwdata_in[`CPLC_CTRL_SUSP_LSB +: 3];
            end
        end
    end

endmodule
`default_nettype wire

// ### hdl/cplc_consts.vh
// constants of the cable port and link power block
`ifndef CPLC_CONSTS_VH
`define CPLC_CONSTS_VH

// register byte offsets
`define CPLC_REG_CTRL 32'h0000_0000
`define CPLC_REG_STATUS 32'h0000_0004
`define CPLC_REG_CONFIG 32'h0000_0008
`define CPLC_REG_ARB 32'h0000_000c

// control register fields
`define CPLC_CTRL_DIS_LSB 0
`define CPLC_CTRL_SUSP_LSB 4

// speed codes
`define CPLC_SPD_S100 2'h0
`define CPLC_SPD_S200 2'h1
`define CPLC_SPD_S400 2'h2

// timing: 25 us of low power status in 10 ns clocks, link-on half period
`define CPLC_LPS_LOW_CYC 12'd2500
`define CPLC_LKON_HALF_CYC 5'd8

// ahb transfer type
`define CPLC_HTRANS_NONSEQ 2'h2

`endif

// ### hdl/cplc_sync.v
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none

module cplc_sync #(
    parameter W = 1
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);

    reg [W-1:0] meta;

    // meta is read by sync_out only, never by logic
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            meta <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule
`default_nettype wire

// ### hdl/cplc_port.v
// enable and connection logic of one cable port
`timescale 1ns/1ps
`default_nettype none

module cplc_port (
    input wire power_down_in,
    input wire rst_in,
    input wire link_disable_in,
    input wire suspend_in,
    input wire core_off_in,
    input wire arb_disable_in,
    input wire bias_detect_in,
    input wire connect_detect_in,
    output wire bias_en_out,
    output wire connected_out,
    output wire port_en_out
);

    // own bias drops on power-down, reset or a link disable command
    assign bias_en_out = ~power_down_in & ~rst_in & ~link_disable_in;
    // own bias off: pair a connect-detect; on: remote bias
    assign connected_out = bias_en_out ? bias_detect_in : connect_detect_in;
    // suspended ports keep only the detectors above alive
    assign port_en_out = ~power_down_in & ~rst_in & connected_out & ~arb_disable_in
                         & ~suspend_in & ~link_disable_in & ~core_off_in;

endmodule
`default_nettype wire

// ### testbench/cplc_llc_model.sv
// behavioural link controller: reports power status, wakes on link-on wave
`timescale 1ns/1ps
`default_nettype none
module cplc_llc_model #(
    parameter int WAKE_CYC = 20
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic sleep_in,
    input wire logic wave_pin_in,
    input wire logic wave_oe_in,
    output logic link_power_status_out
);
    logic last_pin;
    int wake_cnt;
    // power state: sleeps on command, wakes a while after a wave edge is seen
    always @(posedge sys_clk_in)
    begin
        last_pin <= wave_pin_in;
        if (rst_in || sleep_in)
        begin
            link_power_status_out <= rst_in;
            wake_cnt <= 0;
        end
        else if (wake_cnt == WAKE_CYC)
        begin
            link_power_status_out <= 1'b1;
            wake_cnt <= 0;
        end
        else if (wake_cnt > 0 || (wave_oe_in && wave_pin_in != last_pin))
            wake_cnt <= wake_cnt + 1;
    end
endmodule
`default_nettype wire

// ### testbench/cplc_top_properties.sv
// assertions on port enables, link power and link-on wave of the top
`timescale 1ns/1ps
`default_nettype none
`include "cplc_consts.vh"
module cplc_chk (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic power_down_input_in,
    input wire logic link_power_status_in,
    input wire logic linkon_pkt_in,
    input wire logic contender_linkon_pin_in,
    input wire logic [2:0] power_class_inputs_in,
    input wire logic [2:0] arb_disable_in,
    input wire logic contender_linkon_pin_out,
    input wire logic contender_linkon_pin_oe_out,
    input wire logic [2:0] port_trx_en_out,
    input wire logic [2:0] port_bias_output_en_out,
    input wire logic [3:0] self_id_cfg_out,
    input wire logic link_if_active_out
);
    localparam int LOW_CYC = `CPLC_LPS_LOW_CYC;
    int low_cnt;
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    // low run of power status; saturates so it never wraps
    always @(posedge sys_clk_in)
    begin
        if (rst_in || link_power_status_in)
            low_cnt <= 0;
        else if (low_cnt < 4000)
            low_cnt <= low_cnt + 1;
    end
    a_lps_drop: assert property (
        low_cnt == LOW_CYC + 8 |-> !link_if_active_out) else $error("link kept");
    a_lps_early: assert property (
        $fell(link_if_active_out) && !power_down_input_in |-> low_cnt >= LOW_CYC)
        else $error("link dropped early");
    a_wave_start: assert property (
        linkon_pkt_in && !link_if_active_out && !contender_linkon_pin_oe_out
        && !power_down_input_in |=> contender_linkon_pin_oe_out) else $error("no wave");
    a_wave_hold: assert property (
        $rose(contender_linkon_pin_out) |-> (contender_linkon_pin_out [*8])
        or (##[1:8] !contender_linkon_pin_oe_out)) else $error("wave period");
    a_stop_first: assert property (
        $fell(contender_linkon_pin_oe_out) && !power_down_input_in
        |-> !link_if_active_out ##1 link_if_active_out) else $error("stop order");
    a_pd_ports_off: assert property (
        power_down_input_in [*4] |-> port_trx_en_out == 3'h0
        && port_bias_output_en_out == 3'h0) else $error("ports on in power-down");
    a_rst_ports_off: assert property (disable iff (1'b0)
        rst_in |-> port_bias_output_en_out == 3'h0 && port_trx_en_out == 3'h0)
        else $error("ports on in reset");
    a_arb_trx_off: assert property (
        $stable(arb_disable_in) |-> (port_trx_en_out & arb_disable_in) == 3'h0)
        else $error("arbitration disable ignored");
    a_self_id_cfg: assert property (disable iff (1'b0)
        $fell(rst_in) |-> ##3 self_id_cfg_out == {contender_linkon_pin_in, power_class_inputs_in})
        else $error("self-id defaults");
    c_wave: cover property ($rose(contender_linkon_pin_oe_out));
    c_drop: cover property ($fell(link_if_active_out));
    c_pd: cover property (power_down_input_in [*4]);
endmodule
bind cplc_top cplc_chk u_cplc_chk (.*);
`default_nettype wire

// ### testbench/cplc_top_tb.sv
// bench: registers, receive path, link power handshake and power-down
`timescale 1ns/1ps
`default_nettype none
`include "cplc_consts.vh"
module cplc_top_tb;
    logic sys_clk_in, rst_in, hsel_in, hwrite_in, hready_in, rx_bit_clk_in, rx_bit_in, sleep;
    logic rx_active_in, linkon_pkt_in, arb_phase_in, power_down_input_in, link_tx_valid_in;
    logic hreadyout_out, hresp_out, contender_linkon_pin_out, contender_linkon_pin_oe_out;
    logic link_rx_valid_out, link_tx_ready_out, tx_bit_out, rep_bit_out, clock_gen_en_out;
    logic no_cable_active_flag_out, link_if_active_out, core_power_en_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out;
    logic [1:0] htrans_in, rx_speed_in, link_tx_speed_in, next_speed_out;
    logic [2:0] hsize_in, rx_port_in, arb_disable_in, power_class_inputs_in, tx_port_en_out;
    logic [2:0] cable_pair_b_bias_in, cable_pair_a_connect_in, rep_port_en_out, bias_detect_out;
    logic [2:0] port_bias_output_en_out, port_trx_en_out;
    logic [5:0] cable_pair_a_line_in, cable_pair_b_line_in, cable_pair_a_speed_in;
    logic [7:0] link_tx_data_in, link_rx_data_out, rx_seen;
    logic [11:0] arb_status_out;
    logic [3:0] self_id_cfg_out;
    wire link_power_status_in;
    wire contender_linkon_pin_in;
    int n_fail = 0, checked = 0, n_rx = 0;
    // the two-way pin reads its strap (high) unless the block drives it
    assign contender_linkon_pin_in = contender_linkon_pin_oe_out ? contender_linkon_pin_out : 1'b1;
    assign hready_in = hreadyout_out;
    cplc_top u_cplc_top (.*);
    cplc_llc_model u_cplc_llc_model (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .sleep_in(sleep),
        .wave_pin_in(contender_linkon_pin_in), .wave_oe_in(contender_linkon_pin_oe_out),
        .link_power_status_out(link_power_status_in));
    initial
    begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // the valid strobe lasts one cycle, so the group is caught here
    always @(posedge sys_clk_in)
    begin
        if (link_rx_valid_out === 1'b1)
        begin
            n_rx <= n_rx + 1;
            rx_seen <= link_rx_data_out;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_on(ref logic s, input logic v);
        for (int i = 0; s !== v; i++)
        begin
            if (i == 5000)
            begin
                n_fail++;
                report_and_stop();
            end
            @(posedge sys_clk_in);
        end
    endtask
    // one single-word transfer; address phase, then data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel_in <= 1'b1;
        hwrite_in <= wr;
        haddr_in <= a;
        htrans_in <= `CPLC_HTRANS_NONSEQ;
        @(posedge sys_clk_in);
        wait_on(hready_in, 1'b1);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        @(posedge sys_clk_in);
        wait_on(hready_in, 1'b1);
        r = hrdata_out;
        @(posedge sys_clk_in);
    endtask
    task automatic t_regs;
        logic [31:0] r;
        ahb(1'b0, `CPLC_REG_CONFIG, 32'h0, r);
        chk(r, 32'hd);
        ahb(1'b0, `CPLC_REG_ARB, 32'h0, r);
        chk(r, 32'h69c);
        chk(32'(next_speed_out), 32'(`CPLC_SPD_S400));
        arb_disable_in <= 3'h2;
        ahb(1'b1, `CPLC_REG_CTRL, 32'h70, r);
        chk(32'({core_power_en_out, port_trx_en_out}), 32'h0);
        chk(32'(bias_detect_out), 32'h7);
        ahb(1'b1, `CPLC_REG_CTRL, 32'h1, r);
        chk(port_trx_en_out, 3'h4);
        chk(32'(port_bias_output_en_out), 32'h6);
        arb_disable_in <= 3'h0;
        ahb(1'b1, `CPLC_REG_CTRL, 32'h0, r);
        ahb(1'b0, 32'h40, 32'h0, r);
        chk(r, 32'h0);
        $display("t_regs done");
    endtask
    // one packet from port 0, bit clock of 160 ns
    task automatic send_pkt(input logic [1:0] spd, input logic act);
        int n;
        int n0;
        logic [7:0] pat;
        pat = 8'ha5;
        n = 2 << spd;
        n0 = n_rx;
        rx_speed_in <= spd;
        rx_port_in <= 3'h1;
        rx_active_in <= 1'b1;
        for (int b = 0; b < n; b++)
        begin
            rx_bit_in <= pat[7 - b];
            repeat (8) @(posedge sys_clk_in);
            rx_bit_clk_in <= 1'b1;
            repeat (8) @(posedge sys_clk_in);
            rx_bit_clk_in <= 1'b0;
        end
        chk(32'(rep_port_en_out), 32'h6);
        repeat (8) @(posedge sys_clk_in);
        rx_active_in <= 1'b0;
        @(posedge sys_clk_in);
        chk(32'(n_rx - n0), 32'(act));
        if (act)
            chk(32'(rx_seen) & ((32'h1 << n) - 1), 32'ha5 >> (8 - n));
    endtask
    task automatic t_rx;
        wait_on(link_if_active_out, 1'b1);
        for (int s = 0; s < 3; s++)
            send_pkt(2'(s), 1'b1);
        $display("t_rx done");
    endtask
    task automatic t_link;
        sleep <= 1'b1;
        @(posedge sys_clk_in);
        sleep <= 1'b0;
        repeat (2400) @(posedge sys_clk_in);
        chk(32'(link_if_active_out), 32'h1);
        repeat (200) @(posedge sys_clk_in);
        chk(32'(link_if_active_out), 32'h0);
        send_pkt(2'h0, 1'b0);
        linkon_pkt_in <= 1'b1;
        @(posedge sys_clk_in);
        linkon_pkt_in <= 1'b0;
        @(posedge sys_clk_in);
        chk(32'(contender_linkon_pin_oe_out), 32'h1);
        wait_on(link_if_active_out, 1'b1);
        chk(32'(contender_linkon_pin_oe_out), 32'h0);
        $display("t_link done");
    endtask
    task automatic t_tx;
        logic [3:0] got;
        link_tx_speed_in <= `CPLC_SPD_S200;
        link_tx_data_in <= 8'h0b;
        link_tx_valid_in <= 1'b1;
        @(posedge sys_clk_in);
        link_tx_valid_in <= 1'b0;
        @(negedge sys_clk_in);
        chk({link_tx_ready_out, tx_port_en_out}, 4'h7);
        for (int b = 3; b >= 0; b--)
        begin
            @(negedge sys_clk_in);
            got[b] = tx_bit_out;
        end
        chk({link_tx_ready_out, got}, 5'h1b);
        @(posedge sys_clk_in);
        $display("t_tx done");
    endtask
    task automatic t_pd;
        power_down_input_in <= 1'b1;
        {cable_pair_b_bias_in, cable_pair_a_connect_in} <= 6'h0;
        repeat (6) @(posedge sys_clk_in);
        chk(32'({port_trx_en_out, port_bias_output_en_out}), 32'h0);
        chk(32'({clock_gen_en_out, link_if_active_out}), 32'h0);
        chk(32'(no_cable_active_flag_out), 32'h1);
        cable_pair_a_connect_in <= 3'h4;
        repeat (4) @(posedge sys_clk_in);
        chk(32'(no_cable_active_flag_out), 32'h0);
        power_down_input_in <= 1'b0;
        {cable_pair_b_bias_in, cable_pair_a_connect_in} <= 6'h3f;
        wait_on(link_if_active_out, 1'b1);
        $display("t_pd done");
    endtask
    initial
    begin
        rst_in = 1'b1;
        {hsel_in, hwrite_in, rx_bit_clk_in, rx_bit_in, sleep, rx_active_in} = '0;
        {linkon_pkt_in, power_down_input_in, link_tx_valid_in, rx_port_in, arb_disable_in} = '0;
        {haddr_in, hwdata_in, htrans_in, rx_speed_in, link_tx_speed_in, link_tx_data_in} = '0;
        arb_phase_in = 1'b1;
        hsize_in = 3'h2;
        power_class_inputs_in = 3'h5;
        {cable_pair_b_bias_in, cable_pair_a_connect_in} = 6'h3f;
        cable_pair_a_line_in = 6'h1b;
        cable_pair_b_line_in = 6'h24;
        cable_pair_a_speed_in = 6'h12;
        repeat (3) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        t_regs();
        t_rx();
        t_link();
        t_tx();
        t_pd();
        report_and_stop();
    end
endmodule
`default_nettype wire
